// *** logic/lfc_config.sv ***
// lock bit and fuse byte store with protection decode and fuse latching
// What this block does
// [RULE1] both lock bits unprogrammed means no memory protection at all
// [RULE2] lock 10 blocks flash and eeprom writes and locks fuses
// [RULE3] lock 00 blocks flash and eeprom reads and writes, fuses locked
// [RULE4] lock writes only raise protection, otherwise jump to maximum
// [RULE5] only chip erase returns lock bits to unprogrammed
// [RULE6] store program memory allowed over whole flash when self-program fuse is 0
// [RULE7] programmed fuse reads 0, unused bits read 1
// [RULE8] extended byte holds sleep and active brown-out modes and self-program
// [RULE9] high byte holds reset, debug, serial, watchdog, eeprom, brown-out level
// [RULE10] serial-program fuse is hidden from the serial path
// [RULE11] reset-disable or debug fuse programmed kills serial programming
// [RULE12] low byte holds divide-by-eight, clock out, start-up, clock source
// [RULE13] lower lock bit programmed locks all fuse bits
// [RULE14] chip erase leaves fuses unchanged
// [RULE15] fuses latched entering programming mode, changes apply after exit
// [RULE16] eeprom-preserve fuse takes effect immediately
// [RULE17] fuses latched at power-up in normal mode
// [RULE18] chip erase keeps eeprom when eeprom-preserve fuse programmed
// [RULE19] firmware index 0 low, 1 lock, 2 extended, 3 high byte
// [RULE20] latched copy changes only at power-up or mode entry and exit
`include "lfc_defines.svh"
`default_nettype none
module lfc_config
  import lfc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        prog_mode_pin,
  input  wire logic        prog_serial,
  input  wire logic        prog_wr,
  input  wire logic        prog_rd,
  input  wire logic [1:0]  prog_sel,
  input  wire logic [7:0]  prog_wdata,
  input  wire logic        chip_erase,
  output logic       [7:0] prog_rdata,
  output logic             prog_rvalid,
  output logic             prog_rd_refused,
  output logic             prog_wr_refused,
  input  wire logic        fw_rd,
  input  wire logic [15:0] fw_index,
  output logic       [7:0] fw_rdata,
  output logic             fw_rvalid,
  output logic             eeprom_erase,
  output logic             mem_write_block,
  output logic             mem_read_block,
  output logic             fuse_locked,
  output logic             store_program_memory_instruction_en,
  output logic             serial_prog_ok,
  output logic             eeprom_preserve,
  output logic       [7:0] ext_fuse_active,
  output logic       [7:0] high_fuse_active,
  output logic       [7:0] low_fuse_active
);

  lfc_state_t state_ff;
  lfc_state_t nxt_state;

  // protection rank; the reserved code ranks lowest so writing it lands on maximum
  function automatic logic [1:0] lock_rank(input logic [1:0] code);
    logic [1:0] r;
    r = 2'h0;
    unique case (code)
      `LFC_LOCK_NONE:  r = 2'h0;
      `LFC_LOCK_WRITE: r = 2'h1;
      `LFC_LOCK_MAX:   r = 2'h2;
      `LFC_LOCK_RSVD:  r = 2'h0;
    endcase
    return r;
  endfunction

  // byte image for a selector; serial path sees the serial-program bit as 1
  function automatic logic [7:0] pick(input lfc_state_t s, input logic [1:0] sel,
                                      input logic hide);
    logic [7:0] b;
    b = 8'hff;
    unique case (sel)
      `LFC_SEL_LOW:  b = s.low;
      `LFC_SEL_LOCK: b = `LFC_LOCK_UNUSED | {6'h00, s.lock};         // [RULE7]
      `LFC_SEL_EXT:  b = s.ext;
      `LFC_SEL_HIGH: b = s.high | {2'h0, hide, 5'h00};              // [RULE10]
    endcase
    return b;
  endfunction

  logic       path_ok;
  logic       wr_go;
  logic       rd_go;
  logic       fuse_wr;
  logic       chip_go;
  logic [7:0] fuse_val;

  // command qualification; serial path dies when reset pin or debug is taken
  always_comb begin
    path_ok = state_ff.mode && (!prog_serial || state_ff.ser_ok);   // [RULE11]
    wr_go   = prog_wr && path_ok;
    rd_go   = prog_rd && path_ok;
    chip_go = chip_erase && path_ok;
    fuse_wr = wr_go && (prog_sel != `LFC_SEL_LOCK);
    fuse_val = prog_wdata;
    unique case (prog_sel)
      `LFC_SEL_EXT:  fuse_val = prog_wdata | `LFC_EXT_UNUSED;       // [RULE7]
      `LFC_SEL_LOW:  fuse_val = prog_wdata | `LFC_LOW_UNUSED;
      `LFC_SEL_HIGH: fuse_val = prog_serial ?                       // [RULE10]
                       {prog_wdata[7:6], state_ff.high[`LFC_HIGH_SERPROG],
                        prog_wdata[4:0]} : prog_wdata;
      `LFC_SEL_LOCK: fuse_val = prog_wdata;
    endcase
  end

  // next-state of the whole block
  always_comb begin
    nxt_state = state_ff;
    // three-stage pin filter; mode moves when stages two and three agree
    nxt_state.sync = {state_ff.sync[1:0], prog_mode_pin};
    if (state_ff.sync[2] == state_ff.sync[1]) begin
      nxt_state.mode = state_ff.sync[2];
    end
    nxt_state.mode_d     = state_ff.mode;
    nxt_state.pwr_done   = 1'b1;
    nxt_state.rd_valid   = 1'b0;
    nxt_state.rd_refused = prog_rd && !path_ok;
    nxt_state.wr_refused = 1'b0;
    nxt_state.fw_valid   = fw_rd;
    nxt_state.ee_erase   = 1'b0;

    // lock write: raise only, else maximum; never back to 1 here
    if (wr_go && prog_sel == `LFC_SEL_LOCK) begin
      if (lock_rank(prog_wdata[1:0]) > lock_rank(state_ff.lock)) begin
        nxt_state.lock = prog_wdata[1:0];                           // [RULE4]
      end else begin
        nxt_state.lock = `LFC_LOCK_MAX;                             // [RULE4]
      end
    end

    // fuse write refused once the lower lock bit is programmed
    if (fuse_wr) begin
      if (!state_ff.lock[0]) begin
        nxt_state.wr_refused = 1'b1;                                // [RULE13]
      end else begin
        unique case (prog_sel)
          `LFC_SEL_EXT:  nxt_state.ext  = fuse_val;                 // [RULE8]
          `LFC_SEL_HIGH: nxt_state.high = fuse_val;                 // [RULE9]
          `LFC_SEL_LOW:  nxt_state.low  = fuse_val;                 // [RULE12]
          `LFC_SEL_LOCK: nxt_state.low  = state_ff.low;
        endcase
      end
    end
    if (prog_wr && !path_ok) begin
      nxt_state.wr_refused = 1'b1;
    end

    // chip erase clears lock bits only; fuses untouched
    if (chip_go) begin
      nxt_state.lock     = `LFC_LOCK_NONE;                          // [RULE5] [RULE14]
      nxt_state.ee_erase = state_ff.high[`LFC_HIGH_EEKEEP];         // [RULE18]
    end

    // programmer read, one cycle later
    if (rd_go) begin
      nxt_state.rd_valid = 1'b1;
      nxt_state.rd_data  = pick(state_ff, prog_sel, prog_serial);   // [RULE7]
    end

    // firmware read; indices beyond the table read all ones
    if (fw_rd) begin
      nxt_state.fw_data = (fw_index[15:2] == 14'h0000) ?            // [RULE19]
                          pick(state_ff, fw_index[1:0], 1'b0) : 8'hff;
    end

    // latch at first cycle after reset, and on mode entry or exit only
    if (!state_ff.pwr_done || (state_ff.mode != state_ff.mode_d)) begin
      nxt_state.l_ext  = state_ff.ext;                              // [RULE17] [RULE15]
      nxt_state.l_high = state_ff.high;                             // [RULE20]
      nxt_state.l_low  = state_ff.low;
    end

    // decoded controls, registered so every output leaves a flop
    nxt_state.mem_wr_blk = !nxt_state.lock[0] || !nxt_state.lock[1]; // [RULE1] [RULE2] [RULE3]
    nxt_state.mem_rd_blk = (nxt_state.lock == `LFC_LOCK_MAX) ||
                           (nxt_state.lock == `LFC_LOCK_RSVD);      // [RULE3]
    nxt_state.fuse_lock  = !nxt_state.lock[0];                      // [RULE13]
    nxt_state.self_prog_en = !nxt_state.l_ext[`LFC_EXT_SELFPROG];   // [RULE6]
    nxt_state.ser_ok     = nxt_state.l_high[`LFC_HIGH_RSTDIS] &&    // [RULE11]
                           nxt_state.l_high[`LFC_HIGH_DBGWIRE] &&
                           !nxt_state.l_high[`LFC_HIGH_SERPROG];
    // preserve fuse bypasses the latch on purpose
    nxt_state.ee_keep    = !nxt_state.high[`LFC_HIGH_EEKEEP];       // [RULE16]
  end

  // single register for all state; async reset to fresh-part values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff            <= '0;
      state_ff.lock       <= `LFC_LOCK_RST;
      state_ff.ext        <= `LFC_EXT_RST;
      state_ff.high       <= `LFC_HIGH_RST;
      state_ff.low        <= `LFC_LOW_RST;
      state_ff.l_ext      <= `LFC_EXT_RST;
      state_ff.l_high     <= `LFC_HIGH_RST;
      state_ff.l_low      <= `LFC_LOW_RST;
      state_ff.rd_data    <= 8'hff;
      state_ff.fw_data    <= 8'hff;
      state_ff.self_prog_en <= 1'b0;
      state_ff.ser_ok     <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the register image
  assign prog_rdata       = state_ff.rd_data;
  assign prog_rvalid      = state_ff.rd_valid;
  assign prog_rd_refused  = state_ff.rd_refused;
  assign prog_wr_refused  = state_ff.wr_refused;
  assign fw_rdata         = state_ff.fw_data;
  assign fw_rvalid        = state_ff.fw_valid;
  assign eeprom_erase     = state_ff.ee_erase;
  assign mem_write_block  = state_ff.mem_wr_blk;
  assign mem_read_block   = state_ff.mem_rd_blk;
  assign fuse_locked      = state_ff.fuse_lock;
  assign store_program_memory_instruction_en = state_ff.self_prog_en;
  assign serial_prog_ok   = state_ff.ser_ok;
  assign eeprom_preserve  = state_ff.ee_keep;
  assign ext_fuse_active  = state_ff.l_ext;
  assign high_fuse_active = state_ff.l_high;
  assign low_fuse_active  = state_ff.l_low;

  // checks next to the logic
  property p_no_lock;
    @(posedge clk) disable iff (rst)
    (state_ff.lock == `LFC_LOCK_NONE) |-> (!mem_write_block && !mem_read_block);
  endproperty
  a_no_lock: assert property (p_no_lock) // [RULE1]
    else $error("unlocked part shows protection");

  property p_write_lock;
    @(posedge clk) disable iff (rst)
    (state_ff.lock == `LFC_LOCK_WRITE) |-> (mem_write_block && !mem_read_block && fuse_locked);
  endproperty
  a_write_lock: assert property (p_write_lock) // [RULE2]
    else $error("write-lock mode decoded wrongly");

  property p_full_lock;
    @(posedge clk) disable iff (rst)
    (state_ff.lock == `LFC_LOCK_MAX) |-> (mem_write_block && mem_read_block && fuse_locked);
  endproperty
  a_full_lock: assert property (p_full_lock) // [RULE3]
    else $error("full-lock mode decoded wrongly");

  property p_lock_raise;
    @(posedge clk) disable iff (rst)
    (wr_go && prog_sel == `LFC_SEL_LOCK && !chip_go &&
     lock_rank(prog_wdata[1:0]) <= lock_rank(state_ff.lock)) |=> (state_ff.lock == `LFC_LOCK_MAX);
  endproperty
  a_lock_raise: assert property (p_lock_raise) // [RULE4]
    else $error("non-raising lock write did not reach maximum");

  property p_lock_clear;
    @(posedge clk) disable iff (rst)
    $rose(state_ff.lock[0]) || $rose(state_ff.lock[1]) |-> $past(chip_go);
  endproperty
  a_lock_clear: assert property (p_lock_clear) // [RULE5]
    else $error("lock bit returned to 1 without chip erase");

  property p_fuse_locked;
    @(posedge clk) disable iff (rst)
    (fuse_wr && fuse_locked) |=> $stable({state_ff.ext, state_ff.high, state_ff.low});
  endproperty
  a_fuse_locked: assert property (p_fuse_locked) // [RULE13]
    else $error("fuse changed while locked");

  property p_erase_keeps;
    @(posedge clk) disable iff (rst)
    (chip_go && !fuse_wr) |=> $stable({state_ff.ext, state_ff.high, state_ff.low});
  endproperty
  a_erase_keeps: assert property (p_erase_keeps) // [RULE14]
    else $error("chip erase altered a fuse");

  property p_latch_hold;
    @(posedge clk) disable iff (rst)
    (state_ff.pwr_done && state_ff.mode == state_ff.mode_d) |=>
      $stable({state_ff.l_ext, state_ff.l_high, state_ff.l_low});
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [RULE20]
    else $error("latched fuses moved outside a latch event");

  property p_eekeep;
    @(posedge clk) disable iff (rst)
    fuse_wr && !fuse_locked && prog_sel == `LFC_SEL_HIGH |=>
      eeprom_preserve == !$past(prog_wdata[`LFC_HIGH_EEKEEP]);
  endproperty
  a_eekeep: assert property (p_eekeep) // [RULE16]
    else $error("preserve fuse did not act at once");

  property p_fw_lock;
    @(posedge clk) disable iff (rst)
    (fw_rd && fw_index == `LFC_IDX_LOCK) |=>
      (fw_rvalid && fw_rdata == {6'h3f, $past(state_ff.lock)});
  endproperty
  a_fw_lock: assert property (p_fw_lock) // [RULE19]
    else $error("firmware lock read wrong");

  property p_self_prog;
    @(posedge clk) disable iff (rst)
    state_ff.pwr_done |->
      (store_program_memory_instruction_en == !ext_fuse_active[`LFC_EXT_SELFPROG]);
  endproperty
  a_self_prog: assert property (p_self_prog) // [RULE6]
    else $error("self-program enable disagrees with latched fuse");

  property p_serial_dead;
    @(posedge clk) disable iff (rst)
    (prog_rd && prog_serial && !serial_prog_ok) |=> (prog_rd_refused && !prog_rvalid);
  endproperty
  a_serial_dead: assert property (p_serial_dead) // [RULE11]
    else $error("serial read taken while serial path is off");

  property p_fuse_refused;
    @(posedge clk) disable iff (rst)
    (fuse_wr && fuse_locked) |=> prog_wr_refused;
  endproperty
  a_fuse_refused: assert property (p_fuse_refused) // [RULE13]
    else $error("fuse write while locked was not refused");

  property p_erase_ee;
    @(posedge clk) disable iff (rst)
    chip_go |=> (eeprom_erase == $past(state_ff.high[`LFC_HIGH_EEKEEP]));
  endproperty
  a_erase_ee: assert property (p_erase_ee) // [RULE18]
    else $error("eeprom erase pulse disagrees with preserve fuse");

  property p_unused_ones;
    @(posedge clk) disable iff (rst)
    1'b1 |-> (((ext_fuse_active & `LFC_EXT_UNUSED) == `LFC_EXT_UNUSED) &&
              ((low_fuse_active & `LFC_LOW_UNUSED) == `LFC_LOW_UNUSED));
  endproperty
  a_unused_ones: assert property (p_unused_ones) // [RULE7]
    else $error("unused fuse bit reads programmed");

  property p_serial_hide;
    @(posedge clk) disable iff (rst)
    (rd_go && prog_serial && prog_sel == `LFC_SEL_HIGH) |=> prog_rdata[`LFC_HIGH_SERPROG];
  endproperty
  a_serial_hide: assert property (p_serial_hide) // [RULE10]
    else $error("serial path saw the serial-enable fuse");

  property p_fw_range;
    @(posedge clk) disable iff (rst)
    (fw_rd && fw_index[15:2] != 14'h0000) |=> (fw_rvalid && fw_rdata == 8'hff);
  endproperty
  a_fw_range: assert property (p_fw_range) // [RULE19]
    else $error("firmware read beyond the table not all ones");

endmodule // lfc_config
`default_nettype wire

// *** logic/lfc_defines.svh ***
// constants for the lock and fuse configuration block
`ifndef LFC_DEFINES_SVH
`define LFC_DEFINES_SVH
// byte selectors, shared by programmer and firmware pointer index
`define LFC_SEL_LOW       2'h0
`define LFC_SEL_LOCK      2'h1
`define LFC_SEL_EXT       2'h2
`define LFC_SEL_HIGH      2'h3
`define LFC_IDX_LOW       16'h0000
`define LFC_IDX_LOCK      16'h0001
`define LFC_IDX_EXT       16'h0002
`define LFC_IDX_HIGH      16'h0003
// reset values: 0 = programmed, 1 = unprogrammed
`define LFC_LOCK_RST      2'h3
`define LFC_EXT_RST       8'hff
`define LFC_HIGH_RST      8'hdf
`define LFC_LOW_RST       8'h62
// lock encodings
`define LFC_LOCK_NONE     2'h3
`define LFC_LOCK_WRITE    2'h2
`define LFC_LOCK_RSVD     2'h1
`define LFC_LOCK_MAX      2'h0
// unused bit masks, forced to one
`define LFC_LOCK_UNUSED   8'hfc
`define LFC_EXT_UNUSED    8'he0
`define LFC_LOW_UNUSED    8'h20
// field positions
`define LFC_EXT_SELFPROG  0
`define LFC_EXT_ACTBOD    1
`define LFC_EXT_SLPBOD    3
`define LFC_HIGH_BODLVL   0
`define LFC_HIGH_EEKEEP   3
`define LFC_HIGH_WDOG_ON  4
`define LFC_HIGH_SERPROG  5
`define LFC_HIGH_DBGWIRE  6
`define LFC_HIGH_RSTDIS   7
`define LFC_LOW_CKSRC     0
`define LFC_LOW_STARTUP   4
`define LFC_LOW_CLK_OUT   6
`define LFC_LOW_CLK_DIV8  7
`endif

// *** logic/lfc_pkg.sv ***
// types for the lock and fuse configuration block
`default_nettype none
package lfc_pkg;
  // one register image of the whole block
  typedef struct packed {
    logic [2:0] sync;      // programming-mode pin synchroniser
    logic       mode;      // filtered programming mode
    logic       mode_d;    // mode one cycle ago
    logic       pwr_done;  // power-up latch taken
    logic [1:0] lock;      // stored lock bits
    logic [7:0] ext;       // stored fuse bytes
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] l_ext;     // latched fuse bytes
    logic [7:0] l_high;
    logic [7:0] l_low;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       rd_refused;
    logic       wr_refused;
    logic [7:0] fw_data;
    logic       fw_valid;
    logic       ee_erase;
    logic       mem_wr_blk;
    logic       mem_rd_blk;
    logic       fuse_lock;
    logic       self_prog_en;
    logic       ser_ok;
    logic       ee_keep;
  } lfc_state_t;
endpackage
`default_nettype wire

// *** bench/lfc_programmer.sv ***
// programmer and firmware model that drives the configuration block
`default_nettype none
module lfc_programmer (
  input  wire logic        clk,
  output logic             prog_mode_pin,
  output logic             prog_serial,
  output logic             prog_wr,
  output logic             prog_rd,
  output logic             chip_erase,
  output logic       [1:0] prog_sel,
  output logic       [7:0] prog_wdata,
  output logic             fw_rd,
  output logic      [15:0] fw_index
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels from time zero
  initial begin
    {prog_mode_pin, prog_serial, prog_wr, prog_rd, chip_erase, fw_rd} = 6'h00;
    prog_sel = 2'h0;
    prog_wdata = 8'h00;
    fw_index = 16'h0000;
  end

  // one command: kind 0 read, 1 write, 2 chip erase; one-cycle pulse
  task automatic cmd(input logic [1:0] kind, input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk);
    prog_sel <= sel;
    prog_wdata <= d;
    prog_rd <= (kind == 2'h0);
    prog_wr <= (kind == 2'h1);
    chip_erase <= (kind == 2'h2);
    @(posedge clk);
    {prog_rd, prog_wr, chip_erase} <= 3'h0;
    prog_sel <= ~sel;  // released lines never keep the last value
    prog_wdata <= ~d;
    #1;
  endtask

  // firmware configuration read by pointer index
  task automatic fw(input logic [15:0] i);
    @(posedge clk);
    fw_rd <= 1'b1;
    fw_index <= i;
    @(posedge clk);
    fw_rd <= 1'b0;
    fw_index <= ~i;
    #1;
  endtask

  // mode pin is filtered inside, so give it time to settle
  task automatic set_mode(input logic p, input logic s);
    @(posedge clk);
    prog_mode_pin <= p;
    prog_serial <= s;
    repeat (8) @(posedge clk);
    #1;
  endtask
endmodule  // lfc_programmer
`default_nettype wire

// *** bench/lfc_config_bench.sv ***
// self-checking bench for the lock and fuse configuration block
`default_nettype none
module lfc_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, pin, ser_p, wr_p, rd_p, ce_p, fw_p;
  logic [1:0]  sel_p, e_lock;
  logic [7:0]  wd_p, rdat, fdat, ext_a, high_a, low_a;
  logic [15:0] idx_p;
  logic        rv, rrf, wrf, fv, ee, wblk, rblk, flk, sp_en, sok, eep, in_mode, ser;
  logic [7:0]  e_ext, e_high, e_low, l_ext, l_high, l_low;
  logic [31:0] seed;
  int          err_count, checked;

  lfc_programmer lfc_programmer_i (.clk(clk), .prog_mode_pin(pin), .prog_serial(ser_p),
    .prog_wr(wr_p), .prog_rd(rd_p), .chip_erase(ce_p), .prog_sel(sel_p),
    .prog_wdata(wd_p), .fw_rd(fw_p), .fw_index(idx_p));
  lfc_config lfc_config_i (.clk(clk), .rst(rst), .prog_mode_pin(pin), .prog_serial(ser_p),
    .prog_wr(wr_p), .prog_rd(rd_p), .prog_sel(sel_p), .prog_wdata(wd_p), .chip_erase(ce_p),
    .prog_rdata(rdat), .prog_rvalid(rv), .prog_rd_refused(rrf), .prog_wr_refused(wrf),
    .fw_rd(fw_p), .fw_index(idx_p), .fw_rdata(fdat), .fw_rvalid(fv), .eeprom_erase(ee),
    .mem_write_block(wblk), .mem_read_block(rblk), .fuse_locked(flk),
    .store_program_memory_instruction_en(sp_en), .serial_prog_ok(sok),
    .eeprom_preserve(eep), .ext_fuse_active(ext_a), .high_fuse_active(high_a),
    .low_fuse_active(low_a));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // expected byte; serial path sees the serial-enable bit as one
  function automatic logic [7:0] exp_rd(input logic [1:0] s, input logic sr);
    case (s)
      2'h0: return e_low;
      2'h1: return {6'h3f, e_lock};
      2'h2: return e_ext;
      default: return e_high | {2'h0, sr, 5'h00};
    endcase
  endfunction
  function automatic int rank(input logic [1:0] v);
    return (v == 2'h1) ? 0 : (v == 2'h3) ? 1 : (v == 2'h2) ? 2 : 3;
  endfunction
  function automatic logic ok();
    return in_mode && (!ser || (l_high[7] && l_high[6] && !l_high[5]));
  endfunction

  // write with the expected refusal and stored-state update
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    logic ref_e;
    ref_e = !ok() || (s != 2'h1 && !e_lock[0]);
    lfc_programmer_i.cmd(2'h1, s, d);
    chk1("wr_refused", ref_e, wrf);
    if (!ref_e) begin
      case (s)
        2'h0: e_low = d | 8'h20;
        2'h1: e_lock = (rank(d[1:0]) > rank(e_lock)) ? d[1:0] : 2'h0;
        2'h2: e_ext = d | 8'he0;
        default: e_high = ser ? {d[7:6], e_high[5], d[4:0]} : d;
      endcase
    end
  endtask
  task automatic rd(input logic [1:0] s);
    logic ref_e;
    ref_e = !ok();
    lfc_programmer_i.cmd(2'h0, s, 8'h00);
    chk1("rd_refused", ref_e, rrf);
    chk1("rd_valid", !ref_e, rv);
    if (!ref_e) chk8("rd_data", exp_rd(s, ser), rdat);
  endtask
  task automatic erase();
    logic go;
    go = ok();
    lfc_programmer_i.cmd(2'h2, 2'h0, 8'h00);
    chk1("eeprom_erase", go && e_high[3], ee);
    if (go) e_lock = 2'h3;
  endtask
  task automatic fwr(input logic [15:0] i);
    lfc_programmer_i.fw(i);
    chk1("fw_valid", 1'b1, fv);
    chk8("fw_data", (i < 16'h0004) ? exp_rd(i[1:0], 1'b0) : 8'hff, fdat);
  endtask
  // latched copies follow the stored bytes only when the mode flips
  task automatic mode(input logic p, input logic s);
    lfc_programmer_i.set_mode(p, s);
    if (p != in_mode) {l_ext, l_high, l_low} = {e_ext, e_high, e_low};
    in_mode = p;
    ser = s;
  endtask
  task automatic levels();
    @(posedge clk);
    #1;
    chk1("write_block", e_lock != 2'h3, wblk);
    chk1("read_block", !e_lock[1], rblk);
    chk1("fuse_locked", !e_lock[0], flk);
    chk1("self_prog_en", !l_ext[0], sp_en);
    chk1("serial_ok", l_high[7] && l_high[6] && !l_high[5], sok);
    chk1("preserve", !e_high[3], eep);
    chk8("ext_active", l_ext, ext_a);
    chk8("high_active", l_high, high_a);
    chk8("low_active", l_low, low_a);
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    err_count = 0;
    checked = 0;
    seed = 32'h5d6b;
    {e_lock, e_ext, e_high, e_low} = {2'h3, 8'hff, 8'hdf, 8'h62};
    {l_ext, l_high, l_low} = {8'hff, 8'hdf, 8'h62};
    in_mode = 1'b0;
    ser = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    levels();
    for (int i = 0; i < 5; i++) fwr(16'(i));
    erase();
    rd(2'h1);
    wr(2'h0, 8'h00);
    mode(1'b1, 1'b0);
    repeat (6) begin
      seed = xs(seed);
      wr((seed[1:0] == 2'h1) ? 2'h0 : seed[1:0], seed[15:8]);
      rd(seed[1:0]);
    end
    levels();
    wr(2'h3, 8'hd7);
    levels();
    erase();
    fwr(16'h0003);
    wr(2'h3, 8'hdf);
    erase();
    mode(1'b1, 1'b1);
    rd(2'h3);
    wr(2'h3, 8'hbf);
    wr(2'h2, 8'hfe);
    fwr(16'h0003);
    mode(1'b0, 1'b0);
    levels();
    mode(1'b1, 1'b1);
    rd(2'h0);
    erase();
    mode(1'b1, 1'b0);
    wr(2'h3, 8'hdf);
    mode(1'b0, 1'b0);
    mode(1'b1, 1'b0);
    levels();
    wr(2'h1, 8'hfe);
    levels();
    wr(2'h0, 8'h00);
    wr(2'h1, 8'hfe);
    levels();
    wr(2'h1, 8'hff);
    erase();
    levels();
    wr(2'h1, 8'hfd);
    fwr(16'h0001);
    erase();
    wr(2'h1, 8'hff);
    levels();
    print_verdict();
  end
endmodule  // lfc_config_bench
`default_nettype wire
